// ### rtl/usart_baud_ctrl.sv
// Bit-rate generator and receiver/transmitter enable control
`timescale 1ns/1ps
`include "usart_baud_defs.svh"
module usart_baud_ctrl
(
    input wire logic clk,
    input wire logic rstn,
    input usart_baud_pkg::cfg_t cfg,
    input usart_baud_pkg::cmd_t cmd,
    input usart_baud_pkg::dir_busy_t busy,
    input wire logic ratio_wr,
    input wire logic [10:0] ratio_wdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic sample_tick,
    output logic bit_tick,
    output logic rx_enabled,
    output logic tx_enabled,
    output logic rx_soft_reset,
    output logic tx_soft_reset,
    output logic [10:0] card_clock_to_bit_ratio,
    output logic [5:0] rate_adjust_value,
    output logic [11:0] clock_division_value
);
    import usart_baud_pkg::*;

    // Rate adjust factor decode, zero for unused codes
    function automatic logic [5:0] decode_adjust(input logic [3:0] code);
        logic [5:0] v;
        v = 6'h00;
        case (code)
            4'h1: v = 6'h01;
            4'h2: v = 6'h02;
            4'h3: v = 6'h04;
            4'h4: v = 6'h08;
            4'h5: v = 6'h10;
            4'h6: v = 6'h20;
            4'h8: v = 6'h0c;
            4'h9: v = 6'h14;
            default: v = 6'h00;
        endcase
        return v;
    endfunction

    // Clock division factor decode, zero for unused codes
    function automatic logic [11:0] decode_division(input logic [3:0] code);
        logic [11:0] v;
        v = 12'h000;
        case (code)
            4'h0: v = 12'h174;
            4'h1: v = 12'h174;
            4'h2: v = 12'h22e;
            4'h3: v = 12'h2e8;
            4'h4: v = 12'h45c;
            4'h5: v = 12'h5d0;
            4'h6: v = 12'h744;
            4'h9: v = 12'h200;
            4'ha: v = 12'h300;
            4'hb: v = 12'h400;
            4'hc: v = 12'h600;
            4'hd: v = 12'h800;
            default: v = 12'h000;
        endcase
        return v;
    endfunction

    // Disable waits for the busy character; soft reset cuts a disable or a drain straight to off
    function automatic dir_state_t dir_next(input dir_state_t st, input logic en, input logic dis,
                                            input logic srst, input logic busy_now);
        dir_state_t n;
        n = st;
        if (dis)
        begin
            n = (st != DIR_OFF && busy_now && !srst) ? DIR_DRAIN : DIR_OFF;
        end
        else if (en)
        begin
            n = DIR_ON;
        end
        else if (st == DIR_DRAIN && (!busy_now || srst))
        begin
            n = DIR_OFF;
        end
        return n;
    endfunction

    // External clock synchroniser
    logic sck_s1_q;
    logic sck_s2_q;
    logic sck_s3_q;
    logic ext_rise;

    // Generator state
    logic [2:0] prediv_q;
    logic [2:0] prediv_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [2:0] frac_q;
    logic [2:0] frac_d;
    logic extra_q;
    logic extra_d;
    logic phase_q;
    logic phase_d;
    logic phase_n_q;
    logic src_tick;
    logic cd_tick;
    logic frac_active;
    logic [16:0] limit;
    logic [16:0] half;
    logic [3:0] frac_sum;
    logic odd_mck;

    // Output registers
    logic sample_d;
    logic bit_d;
    logic sck_oe_d;
    logic ovs_tick;
    logic etu_tick;
    logic [10:0] ovs_ratio;
    logic [10:0] ratio_d;
    dir_state_t rx_q;
    dir_state_t rx_d;
    dir_state_t tx_q;
    dir_state_t tx_d;
    logic tx_busy;

    // Pin passes two flops before the edge detector reads it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
        end
        else
        begin
            sck_s1_q <= sck_in;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    assign ext_rise = sck_s2_q & ~sck_s3_q;

    always_comb
    begin
        prediv_d = prediv_q + 3'h1;
        case (cfg.source_clock_select)
            `SRC_MCK: src_tick = 1'b1;
            `SRC_MCK_DIV: src_tick = (prediv_q == `PREDIV_LAST);
            default: src_tick = ext_rise;
        endcase
    end

    assign frac_active = (cfg.mode == MODE_NORMAL) && (cfg.fraction_part != 3'h0);
    assign limit = {1'b0, cfg.clock_divisor} + {16'h0000, extra_q};
    assign half = (limit + 17'h00001) >> 1;
    assign frac_sum = {1'b0, frac_q} + {1'b0, cfg.fraction_part};
    assign odd_mck = cfg.clock_divisor[0] && (cfg.source_clock_select == `SRC_MCK);

    // Main divider; the carry of the fraction stretches one period by one source tick
    always_comb
    begin
        cnt_d = cnt_q;
        frac_d = frac_q;
        extra_d = extra_q;
        phase_d = phase_q;
        cd_tick = 1'b0;
        if (cfg.clock_divisor == 16'h0000)
        begin
            cnt_d = 16'h0000;
            extra_d = 1'b0;
            phase_d = 1'b0;
        end
        else if (cfg.clock_divisor == 16'h0001)
        begin
            cnt_d = 16'h0000;
            extra_d = 1'b0;
            cd_tick = src_tick;
            phase_d = cfg.source_clock_select == `SRC_MCK ? 1'b1 : (src_tick ? ~phase_q : phase_q);
        end
        else if (src_tick)
        begin
            if ({1'b0, cnt_q} >= limit - 17'h00001)
            begin
                cnt_d = 16'h0000;
                cd_tick = 1'b1;
                phase_d = 1'b1;
                frac_d = frac_active ? frac_sum[2:0] : 3'h0;
                extra_d = frac_active & frac_sum[3];
            end
            else
            begin
                cnt_d = cnt_q + 16'h0001;
                phase_d = ({1'b0, cnt_d} < half);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prediv_q <= 3'h0;
            cnt_q <= 16'h0000;
            frac_q <= 3'h0;
            extra_q <= 1'b0;
            phase_q <= 1'b0;
        end
        else
        begin
            prediv_q <= prediv_d;
            cnt_q <= cnt_d;
            frac_q <= frac_d;
            extra_q <= extra_d;
            phase_q <= phase_d;
        end
    end

    // Half-cycle copy trims the high phase of an odd divisor above 1 to an exact half, with the master clock (SRC_MCK) as source only
    always_ff @(negedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_n_q <= 1'b0;
        end
        else
        begin
            phase_n_q <= phase_q;
        end
    end

    assign ovs_ratio = cfg.oversample_8 ? `OVS_8 : `OVS_16;

    rate_divider ovs_div
    (
        .clk(clk),
        .rstn(rstn),
        .tick_in(cd_tick && cfg.mode == MODE_NORMAL),
        .ratio(ovs_ratio),
        .tick_out(ovs_tick)
    );

    rate_divider etu_div
    (
        .clk(clk),
        .rstn(rstn),
        .tick_in(cd_tick && cfg.mode == MODE_CARD),
        .ratio(card_clock_to_bit_ratio),
        .tick_out(etu_tick)
    );

    // Rate selection per mode; all rates leave as one-cycle pulses unless a divisor of 1 on SRC_MCK holds cd_tick high
    always_comb
    begin
        sample_d = 1'b0;
        bit_d = 1'b0;
        sck_oe_d = 1'b0;
        case (cfg.mode)
            MODE_NORMAL:
            begin
                sample_d = cd_tick;
                bit_d = ovs_tick;
            end
            MODE_SYNC:
            begin
                bit_d = (cfg.source_clock_select == `SRC_EXT) ? ext_rise : cd_tick;
                sample_d = bit_d;
                sck_oe_d = cfg.clock_output_enable && cfg.source_clock_select != `SRC_EXT;
            end
            MODE_CARD:
            begin
                sample_d = cd_tick;
                bit_d = etu_tick;
                sck_oe_d = cfg.clock_output_enable;
            end
            default:
            begin
                sample_d = 1'b0;
                bit_d = 1'b0;
            end
        endcase
    end

    assign ratio_d = ratio_wr ? ratio_wdata : card_clock_to_bit_ratio;

    assign tx_busy = busy.tx_shift_busy | busy.tx_holding_full | busy.tx_guard_busy;

    always_comb
    begin
        rx_d = dir_next(rx_q, cmd.receiver_enable_cmd, cmd.receiver_disable_cmd,
                        cmd.receiver_soft_reset_cmd, busy.rx_char_busy);
        tx_d = dir_next(tx_q, cmd.transmitter_enable_cmd, cmd.transmitter_disable_cmd,
                        cmd.transmitter_soft_reset_cmd, tx_busy);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_q <= DIR_OFF;
            tx_q <= DIR_OFF;
            rx_enabled <= 1'b0;
            tx_enabled <= 1'b0;
            rx_soft_reset <= 1'b0;
            tx_soft_reset <= 1'b0;
            card_clock_to_bit_ratio <= `RATIO_RESET;
            rate_adjust_value <= 6'h00;
            clock_division_value <= 12'h000;
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
            sck_oe <= 1'b0;
        end
        else
        begin
            rx_q <= rx_d;
            tx_q <= tx_d;
            rx_enabled <= (rx_d != DIR_OFF);
            tx_enabled <= (tx_d != DIR_OFF);
            rx_soft_reset <= cmd.receiver_soft_reset_cmd;
            tx_soft_reset <= cmd.transmitter_soft_reset_cmd;
            card_clock_to_bit_ratio <= ratio_d;
            rate_adjust_value <= decode_adjust(cfg.rate_adjust_code);
            clock_division_value <= decode_division(cfg.clock_division_code);
            sample_tick <= sample_d;
            bit_tick <= bit_d;
            sck_oe <= sck_oe_d;
        end
    end

    // Only the gated pin path uses both edges; the ticks stay single-edge
    assign sck_out = odd_mck ? (phase_q & phase_n_q) : phase_q;

endmodule // usart_baud_ctrl

// ### rtl/usart_baud_defs.svh
// Constants for the serial port bit-rate generator
`ifndef USART_BAUD_DEFS_SVH
`define USART_BAUD_DEFS_SVH

`define SRC_MCK 2'h0
`define SRC_MCK_DIV 2'h1
`define SRC_EXT 2'h3
`define PREDIV_LAST 3'h7
`define OVS_16 11'h010
`define OVS_8 11'h008
`define RATIO_RESET 11'h174
`define FRAC_W 3

`endif

// ### rtl/usart_baud_pkg.sv
// Types shared by the bit-rate generator, its checker and its bench
package usart_baud_pkg;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_SYNC, MODE_CARD} op_mode_t;

    typedef enum logic [1:0] {DIR_OFF, DIR_ON, DIR_DRAIN} dir_state_t;

    typedef struct packed {
        op_mode_t mode;
        logic [1:0] source_clock_select;
        logic clock_output_enable;
        logic oversample_8;
        logic [15:0] clock_divisor;
        logic [2:0] fraction_part;
        logic [3:0] rate_adjust_code;
        logic [3:0] clock_division_code;
    } cfg_t;

    typedef struct packed {
        logic receiver_enable_cmd;
        logic receiver_disable_cmd;
        logic receiver_soft_reset_cmd;
        logic transmitter_enable_cmd;
        logic transmitter_disable_cmd;
        logic transmitter_soft_reset_cmd;
    } cmd_t;

    typedef struct packed {
        logic rx_char_busy;
        logic tx_shift_busy;
        logic tx_holding_full;
        logic tx_guard_busy;
    } dir_busy_t;

endpackage

// ### rtl/rate_divider.sv
// Pulse divider: one output pulse per ratio input pulses
`timescale 1ns/1ps
module rate_divider
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick_in,
    input wire logic [10:0] ratio,
    output logic tick_out
);
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic tick_d;

    // Ratio zero gives no pulse at all
    always_comb
    begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (ratio == 11'h000)
        begin
            cnt_d = 11'h000;
        end
        else if (tick_in)
        begin
            if (cnt_q >= ratio - 11'h001)
            begin
                cnt_d = 11'h000;
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 11'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= 11'h000;
            tick_out <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_out <= tick_d;
        end
    end
endmodule // rate_divider

// ### dv/sck_source.sv
// Far-side serial clock source for the external clock path
`timescale 1ns/1ps
module sck_source
#(
    parameter int HALF_NS = 100
)
(
    input wire logic run,
    output logic sck
);
    // Ten master cycles a period; parks low between bursts
    initial
    begin
        sck = 1'b0;
        forever
        begin
            wait (run);
            #HALF_NS sck = 1'b1;
            #HALF_NS sck = 1'b0;
        end
    end
endmodule // sck_source

// ### dv/usart_baud_ctrl_checker.sv
// Port-level checks on the bit-rate generator and direction control
`timescale 1ns/1ps
module usart_baud_ctrl_checker
(
    input wire logic clk,
    input wire logic rstn,
    input usart_baud_pkg::cfg_t cfg,
    input usart_baud_pkg::cmd_t cmd,
    input usart_baud_pkg::dir_busy_t busy,
    input wire logic ratio_wr,
    input wire logic [10:0] ratio_wdata,
    input wire logic sample_tick,
    input wire logic bit_tick,
    input wire logic rx_enabled,
    input wire logic tx_enabled,
    input wire logic rx_soft_reset,
    input wire logic tx_soft_reset,
    input wire logic [10:0] card_clock_to_bit_ratio
);
    import usart_baud_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_rx_drain;
        cmd.receiver_disable_cmd && !cmd.receiver_soft_reset_cmd && busy.rx_char_busy;
    endsequence
    sequence s_rx_pulse;
        rx_soft_reset ##1 !rx_soft_reset;
    endsequence
    property p_rx_on;
        cmd.receiver_enable_cmd && !cmd.receiver_disable_cmd |=> rx_enabled;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receiver not enabled");
    property p_tx_on;
        cmd.transmitter_enable_cmd && !cmd.transmitter_disable_cmd |=> tx_enabled;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("transmitter not enabled");
    property p_rx_drain;
        rx_enabled ##0 s_rx_drain |=> rx_enabled;
    endproperty
    a_rx_drain: assert property (p_rx_drain) else $error("receiver stopped mid character");
    property p_tx_drain;
        tx_enabled && cmd.transmitter_disable_cmd && !cmd.transmitter_soft_reset_cmd && (|busy[2:0]) |=> tx_enabled;
    endproperty
    a_tx_drain: assert property (p_tx_drain) else $error("transmitter stopped early");
    property p_rx_srst;
        cmd.receiver_soft_reset_cmd ##1 !cmd.receiver_soft_reset_cmd |-> s_rx_pulse;
    endproperty
    a_rx_srst: assert property (p_rx_srst) else $error("receiver soft reset pulse wrong");
    property p_tx_srst;
        cmd.transmitter_soft_reset_cmd |=> tx_soft_reset;
    endproperty
    a_tx_srst: assert property (p_tx_srst) else $error("transmitter soft reset missing");
    property p_ratio;
        ratio_wr |=> card_clock_to_bit_ratio == $past(ratio_wdata);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio write lost");
    property p_no_tick;
        (cfg.clock_divisor == 16'h0000 && cfg.mode != MODE_SYNC)[*4] |-> !sample_tick && !bit_tick;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("tick with zero divisor");
    property p_bit_pulse;
        $stable(cfg) && cfg.mode == MODE_NORMAL && bit_tick |=> !bit_tick;
    endproperty
    a_bit_pulse: assert property (p_bit_pulse) else $error("bit tick longer than one cycle");
endmodule // usart_baud_ctrl_checker

bind usart_baud_ctrl usart_baud_ctrl_checker usart_baud_ctrl_checker_i (.clk(clk), .rstn(rstn), .cfg(cfg),
    .cmd(cmd), .busy(busy), .ratio_wr(ratio_wr), .ratio_wdata(ratio_wdata), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .rx_enabled(rx_enabled), .tx_enabled(tx_enabled), .rx_soft_reset(rx_soft_reset),
    .tx_soft_reset(tx_soft_reset), .card_clock_to_bit_ratio(card_clock_to_bit_ratio));

// ### dv/usart_baud_ctrl_tb.sv
// Self-checking bench for the bit-rate generator and direction control
`timescale 1ns/1ps
`define check_eq(n, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("unexpected %s exp %0d got %0d", n, e, g); \
        end \
    end
module usart_baud_ctrl_tb;
    import usart_baud_pkg::*;
    logic clk, rstn, ratio_wr, sck_in, sck_out, sck_oe, sample_tick, bit_tick;
    logic rx_enabled, tx_enabled, rx_soft_reset, tx_soft_reset;
    logic run;
    logic [10:0] ratio_wdata, card_clock_to_bit_ratio;
    logic [5:0] rate_adjust_value;
    logic [11:0] clock_division_value;
    cfg_t cfg;
    cmd_t cmd;
    dir_busy_t busy;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int n, hi;
    int di[16] = '{0, 1, 2, 4, 8, 16, 32, 0, 12, 20, 0, 0, 0, 0, 0, 0};
    int fi[16] = '{372, 372, 558, 744, 1116, 1488, 1860, 0, 0, 512, 768, 1024, 1536, 2048, 0, 0};
    usart_baud_ctrl usart_baud_ctrl_i (.clk(clk), .rstn(rstn), .cfg(cfg), .cmd(cmd), .busy(busy),
        .ratio_wr(ratio_wr), .ratio_wdata(ratio_wdata), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .sample_tick(sample_tick), .bit_tick(bit_tick), .rx_enabled(rx_enabled), .tx_enabled(tx_enabled),
        .rx_soft_reset(rx_soft_reset), .tx_soft_reset(tx_soft_reset),
        .card_clock_to_bit_ratio(card_clock_to_bit_ratio), .rate_adjust_value(rate_adjust_value),
        .clock_division_value(clock_division_value));
    sck_source sck_source_i (.run(run), .sck(sck_in));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic pulse(input cmd_t c);
        cmd = c;
        cyc(1);
        cmd = '0;
    endtask
    // Third gap is measured; the first two absorb the config change
    task automatic rate(input op_mode_t m, input logic [1:0] s, input logic o8, input logic [15:0] d,
        input logic [2:0] f, input logic bt, input int e);
        cfg = {m, s, 1'b1, o8, d, f, cfg.rate_adjust_code, cfg.clock_division_code};
        repeat (3)
        begin
            cyc(1);
            n = 1;
            while ((bt ? bit_tick : sample_tick) !== 1'b1 && n < 200)
            begin
                cyc(1);
                n++;
            end
        end
        `check_eq("tick period", e, n)
    endtask
    initial
    begin
        rstn = 1'b0;
        run = 1'b0;
        cmd = '0;
        busy = '0;
        cfg = '0;
        ratio_wr = 1'b0;
        ratio_wdata = 11'h004;
        cyc(20);
        rstn = 1'b1;
        cyc(1);
        `check_eq("rx_enabled", 1'b0, rx_enabled)
        `check_eq("tx_enabled", 1'b0, tx_enabled)
        `check_eq("ratio", 11'h174, card_clock_to_bit_ratio)
        for (int i = 0; i < 16; i++)
        begin
            cfg.rate_adjust_code = 4'(i);
            cfg.clock_division_code = 4'(i);
            cyc(2);
            `check_eq("rate adjust", 6'(di[i]), rate_adjust_value)
            `check_eq("clock division", 12'(fi[i]), clock_division_value)
        end
        rate(MODE_NORMAL, 2'h0, 1'b0, 16'h0002, 3'h0, 1'b0, 2);
        rate(MODE_NORMAL, 2'h0, 1'b0, 16'h0002, 3'h0, 1'b1, 32);
        rate(MODE_NORMAL, 2'h0, 1'b1, 16'h0002, 3'h0, 1'b1, 16);
        rate(MODE_NORMAL, 2'h0, 1'b0, 16'h0002, 3'h4, 1'b1, 40);
        rate(MODE_NORMAL, 2'h0, 1'b1, 16'h0001, 3'h0, 1'b1, 8);
        rate(MODE_NORMAL, 2'h0, 1'b0, 16'h0000, 3'h0, 1'b0, 200);
        rate(MODE_NORMAL, 2'h1, 1'b0, 16'h0002, 3'h0, 1'b0, 16);
        rate(MODE_SYNC, 2'h0, 1'b0, 16'h0005, 3'h4, 1'b1, 5);
        hi = 0;
        repeat (20)
        begin
            @(posedge clk);
            #5 hi += int'(sck_out);
            @(negedge clk);
            #5 hi += int'(sck_out);
        end
        `check_eq("sck duty", 20, hi)
        cyc(1);
        ratio_wr = 1'b1;
        cyc(1);
        ratio_wr = 1'b0;
        `check_eq("ratio", 11'h004, card_clock_to_bit_ratio)
        rate(MODE_CARD, 2'h0, 1'b0, 16'h0002, 3'h4, 1'b0, 2);
        `check_eq("pin drive", 1'b1, sck_oe)
        rate(MODE_CARD, 2'h0, 1'b0, 16'h0002, 3'h0, 1'b1, 8);
        run = 1'b1;
        rate(MODE_SYNC, 2'h3, 1'b0, 16'h0007, 3'h0, 1'b1, 10);
        run = 1'b0;
        `check_eq("pin drive", 1'b0, sck_oe)
        pulse(6'h20);
        `check_eq("rx only", 2'h2, {rx_enabled, tx_enabled})
        busy = 4'h8;
        cyc(1);
        pulse(6'h10);
        cyc(3);
        `check_eq("rx draining", 1'b1, rx_enabled)
        busy = '0;
        cyc(2);
        `check_eq("rx off", 1'b0, rx_enabled)
        pulse(6'h24);
        `check_eq("both on", 2'h3, {rx_enabled, tx_enabled})
        busy = 4'h6;
        cyc(1);
        pulse(6'h02);
        cyc(2);
        busy = 4'h1;
        cyc(2);
        `check_eq("tx draining", 1'b1, tx_enabled)
        busy = '0;
        cyc(2);
        `check_eq("tx off", 1'b0, tx_enabled)
        busy = 4'h8;
        pulse(6'h10);
        cyc(1);
        pulse(6'h08);
        `check_eq("rx soft reset", 2'h2, {rx_soft_reset, rx_enabled})
        cyc(1);
        pulse(6'h01);
        `check_eq("tx soft reset", 1'b1, tx_soft_reset)
        `check_eq("ratio kept", 11'h004, card_clock_to_bit_ratio)
        wrap_up();
    end
endmodule // usart_baud_ctrl_tb
